// File: core/bjd_pkg.sv
// Package: constants and carriers for the boot jump and memory decode block
package bjd_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int WIN_SW_W = 6;
  localparam int WIN_OFS_W = 10;
  localparam int WIN_BYTES = 1024;
  localparam int PROM_CHIPS = 4;
  localparam int PROM_CHIP_W = 8;
  localparam logic [7:0] SWITCH_PORT_OFS = 8'hff;
  localparam logic [7:0] JUMP_OPCODE = 8'hc3;
  localparam logic [7:0] JUMP_LOW_BYTE = 8'h00;
  localparam logic [7:0] FLOAT_BYTE = 8'hff;

  // Start sequence states; codes are one-hot, order follows the strobe count
  typedef enum logic [3:0] {
    BJD_ST_OPCODE = 4'h1,
    BJD_ST_LOW = 4'h2,
    BJD_ST_HIGH = 4'h4,
    BJD_ST_RUN = 4'h8
  } bjd_seq_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_out;
    logic memory_cycle;
    logic input_cycle;
    logic output_cycle;
    logic interrupt_cycle;
    logic halt_cycle;
    logic data_in_strobe;
    logic memory_write_pulse;
  } bjd_bus_s;

  typedef struct packed {
    logic [DATA_W-1:0] data_in;
    logic data_in_enable;
    logic wait_request;
    logic memory_read_hold_n;
  } bjd_resp_s;
endpackage

// File: core/bjd_ram.sv
// Module: 1 KB byte RAM built from flip-flops
`timescale 1ns/1ps
module bjd_ram #(
  parameter int DEPTH = bjd_pkg::WIN_BYTES,
  parameter int AW = bjd_pkg::WIN_OFS_W,
  parameter int DW = bjd_pkg::DATA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Access port
  input wire logic select,
  input wire logic write,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] rdata;
  } bjd_ram_s;

  bjd_ram_s st_q;
  bjd_ram_s st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.rdata = st_q.mem[addr];
    if (select && write)
    begin
      st_d.mem[addr] = wdata;
      st_d.rdata = wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign rdata = st_q.rdata;
endmodule // bjd_ram

// File: core/bjd_top.sv
// Module: board memory windows, switch port and start jump injection
`timescale 1ns/1ps
module bjd_top #(
  parameter int PROM_CHIP_COUNT = bjd_pkg::PROM_CHIPS
) (
  // Clock and bus reset (active low, restarts start sequence)
  input wire logic clk,
  input wire logic reset_n,
  // System bus from the processor
  input wire bjd_pkg::bjd_bus_s bus,
  // Answer onto the data-in bus
  output bjd_pkg::bjd_resp_s resp,
  // Board switches, one means toward the arrow
  input wire logic [bjd_pkg::WIN_SW_W-1:0] ram_window_sw,
  input wire logic [bjd_pkg::WIN_SW_W-1:0] prom_window_sw,
  input wire logic [bjd_pkg::DATA_W-1:0] start_address_sw,
  input wire logic [bjd_pkg::DATA_W-1:0] switch_input_port,
  // PROM chip port
  output logic [PROM_CHIP_COUNT-1:0] prom_chip_select,
  output logic [bjd_pkg::PROM_CHIP_W-1:0] prom_addr,
  input wire logic [bjd_pkg::DATA_W-1:0] prom_data,
  // Status
  output logic jump_in_progress
);
  typedef struct packed {
    bjd_pkg::bjd_seq_e seq;
    logic strobe_prev;
    bjd_pkg::bjd_resp_s resp;
    logic [PROM_CHIP_COUNT-1:0] prom_cs;
    logic [bjd_pkg::PROM_CHIP_W-1:0] prom_addr;
  } bjd_state_s;

  localparam int CHIP_SEL_W = (PROM_CHIP_COUNT > 1) ? $clog2(PROM_CHIP_COUNT) : 1;

  bjd_state_s st_q;
  bjd_state_s st_d;

  logic prom_hit;
  logic ram_hit;
  logic port_hit;
  logic ram_select;
  logic ram_write;
  logic jump_phase_flop;
  logic strobe_fall;
  logic [bjd_pkg::DATA_W-1:0] ram_rdata;
  logic [bjd_pkg::DATA_W-1:0] inject_byte;
  logic [CHIP_SEL_W-1:0] chip_idx;

  // Window compare on top six address bits
  assign prom_hit = bus.memory_cycle
    && (bus.addr[bjd_pkg::ADDR_W-1 -: bjd_pkg::WIN_SW_W] == prom_window_sw);
  assign ram_hit = (bus.memory_cycle || bus.halt_cycle)
    && (bus.addr[bjd_pkg::ADDR_W-1 -: bjd_pkg::WIN_SW_W] == ram_window_sw);
  assign port_hit = bus.input_cycle && (bus.addr[7:0] == bjd_pkg::SWITCH_PORT_OFS);

  // RAM answers only in memory or halt cycles outside the start sequence
  assign jump_phase_flop = (st_q.seq != bjd_pkg::BJD_ST_RUN);
  assign ram_select = ram_hit && !jump_phase_flop && !bus.input_cycle
    && !bus.output_cycle && !bus.interrupt_cycle;
  assign ram_write = ram_select && bus.memory_write_pulse;
  // Advance at the end of the pulse so each injected byte stands for the whole read
  assign strobe_fall = !bus.data_in_strobe && st_q.strobe_prev;
  assign chip_idx = CHIP_SEL_W'(bus.addr[bjd_pkg::WIN_OFS_W-1 -: 2]);

  bjd_ram #(
    .DEPTH(bjd_pkg::WIN_BYTES),
    .AW(bjd_pkg::WIN_OFS_W),
    .DW(bjd_pkg::DATA_W)
  ) u_ram (
    .clk(clk),
    .reset_n(reset_n),
    .select(ram_select),
    .write(ram_write),
    .addr(bus.addr[bjd_pkg::WIN_OFS_W-1:0]),
    .wdata(bus.data_out),
    .rdata(ram_rdata)
  );

  // Injected byte; low byte zero makes the target switch value times 256
  always_comb
  begin
    case (st_q.seq)
      bjd_pkg::BJD_ST_OPCODE: inject_byte = bjd_pkg::JUMP_OPCODE;
      bjd_pkg::BJD_ST_LOW: inject_byte = bjd_pkg::JUMP_LOW_BYTE;
      bjd_pkg::BJD_ST_HIGH: inject_byte = start_address_sw;
      default: inject_byte = bjd_pkg::FLOAT_BYTE;
    endcase
  end

  always_comb
  begin
    st_d = st_q;
    st_d.strobe_prev = bus.data_in_strobe;
    // One state per data-in strobe
    if (strobe_fall)
    begin
      case (st_q.seq)
        bjd_pkg::BJD_ST_OPCODE: st_d.seq = bjd_pkg::BJD_ST_LOW;
        bjd_pkg::BJD_ST_LOW: st_d.seq = bjd_pkg::BJD_ST_HIGH;
        bjd_pkg::BJD_ST_HIGH: st_d.seq = bjd_pkg::BJD_ST_RUN;
        bjd_pkg::BJD_ST_RUN: st_d.seq = bjd_pkg::BJD_ST_RUN;
        default: st_d.seq = bjd_pkg::BJD_ST_OPCODE;
      endcase
    end
    // Memory read held low while jump bytes go out
    st_d.resp.memory_read_hold_n = !jump_phase_flop;
    // PROM decode enabled by window hit, one chip per 256 bytes
    st_d.prom_cs = '0;
    st_d.prom_addr = bus.addr[bjd_pkg::PROM_CHIP_W-1:0];
    if (prom_hit && !jump_phase_flop && (32'(chip_idx) < PROM_CHIP_COUNT))
      st_d.prom_cs[chip_idx] = 1'b1;
    // Wait request for PROM or port hits
    st_d.resp.wait_request = (prom_hit || port_hit) && !jump_phase_flop;
    st_d.resp.data_in_enable = 1'b0;
    st_d.resp.data_in = bjd_pkg::FLOAT_BYTE;
    if (jump_phase_flop)
    begin
      // Injected byte wins over any memory during the sequence
      st_d.resp.data_in_enable = 1'b1;
      st_d.resp.data_in = inject_byte;
    end
    else if (port_hit)
    begin
      st_d.resp.data_in_enable = 1'b1;
      st_d.resp.data_in = switch_input_port;
    end
    else if (prom_hit)
    begin
      st_d.resp.data_in_enable = 1'b1;
      st_d.resp.data_in = prom_data;
    end
    else if (ram_select && !bus.memory_write_pulse)
    begin
      // Direction reversed on write, so no drive then
      st_d.resp.data_in_enable = 1'b1;
      st_d.resp.data_in = ram_rdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q.seq <= bjd_pkg::BJD_ST_OPCODE;
      st_q.strobe_prev <= 1'b0;
      st_q.resp <= '{data_in: 8'hff, data_in_enable: 1'b0, wait_request: 1'b0,
                     memory_read_hold_n: 1'b0};
      st_q.prom_cs <= '0;
      st_q.prom_addr <= '0;
    end
    else
      st_q <= st_d;
  end

  assign resp = st_q.resp;
  assign prom_chip_select = st_q.prom_cs;
  assign prom_addr = st_q.prom_addr;
  assign jump_in_progress = jump_phase_flop;
endmodule // bjd_top

// File: verification/bjd_checker.sv
// Port assertions for the boot jump decode block
`timescale 1ns/1ps
module bjd_checker #(
  parameter int PROM_CHIP_COUNT = 4
) (
  // Clock, reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus
  input wire bjd_pkg::bjd_bus_s bus,
  input wire bjd_pkg::bjd_resp_s resp,
  // Board
  input wire logic [5:0] ram_window_sw,
  input wire logic [5:0] prom_window_sw,
  input wire logic [7:0] start_address_sw,
  input wire logic [7:0] switch_input_port,
  input wire logic [PROM_CHIP_COUNT-1:0] prom_chip_select,
  input wire logic [7:0] prom_addr,
  input wire logic jump_in_progress
);
  logic stb_q;
  logic [1:0] seen_q;
  wire jp = jump_in_progress;
  wire prom = bus.memory_cycle && bus.addr[15:10] == prom_window_sw;
  wire port = bus.input_cycle && bus.addr[7:0] == 8'hff;
  wire ram = !jp && (bus.memory_cycle || bus.halt_cycle) && !bus.input_cycle && !bus.interrupt_cycle
    && !bus.output_cycle && bus.addr[15:10] == ram_window_sw;
  // Strobe pulses ended since reset, saturating at three
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      {stb_q, seen_q} <= 3'h0;
    else
      {stb_q, seen_q} <= {bus.data_in_strobe, seen_q + 2'(!bus.data_in_strobe && stb_q && seen_q != 2'h3)};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_seq; jp == (seen_q != 2'h3); endproperty
  a_seq: assert property (p_seq) else $error("bad length");
  property p_jmp; jp |=> resp.data_in_enable && resp.data_in ==
    ($past(seen_q) == 2'h0 ? 8'hc3 : $past(seen_q) == 2'h1 ? 8'h00 : $past(start_address_sw)); endproperty
  a_jmp: assert property (p_jmp) else $error("bad jump byte");
  property p_hold; resp.memory_read_hold_n == !$past(jp); endproperty
  a_hold: assert property (p_hold) else $error("bad hold");
  property p_wait; !jp |=> resp.wait_request == $past(prom || port); endproperty
  a_wait: assert property (p_wait) else $error("bad wait");
  property p_port; !jp && port |=> resp.data_in_enable && resp.data_in == $past(switch_input_port); endproperty
  a_port: assert property (p_port) else $error("bad port");
  property p_prom; !jp && prom |=> $onehot(prom_chip_select) && prom_chip_select[$past(bus.addr[9:8])]
    && prom_addr == $past(bus.addr[7:0]); endproperty
  a_prom: assert property (p_prom) else $error("bad prom");
  property p_ram; ram && !bus.memory_write_pulse |=> resp.data_in_enable; endproperty
  a_ram: assert property (p_ram) else $error("bad ram read");
  property p_dir; ram && bus.memory_write_pulse |=> !resp.data_in_enable; endproperty
  a_dir: assert property (p_dir) else $error("bad ram write");
endmodule // bjd_checker

bind bjd_top bjd_checker #(.PROM_CHIP_COUNT(PROM_CHIP_COUNT)) i_bjd_checker (.clk(clk), .reset_n(reset_n),
  .bus(bus), .resp(resp), .ram_window_sw(ram_window_sw), .prom_window_sw(prom_window_sw),
  .start_address_sw(start_address_sw), .switch_input_port(switch_input_port),
  .prom_chip_select(prom_chip_select), .prom_addr(prom_addr), .jump_in_progress(jump_in_progress));

// File: verification/bjd_cpu.sv
// Processor model driving one bus cycle at a time
`timescale 1ns/1ps
module bjd_cpu (
  // Clock
  input wire logic clk,
  // System bus
  output bjd_pkg::bjd_bus_s bus,
  input wire bjd_pkg::bjd_resp_s resp
);
  initial bus = '0;
  // k is memory, input, output, interrupt, halt; slow stretches the cycle
  task automatic acc(input logic [4:0] k, input logic [15:0] a, input logic [7:0] d, input logic w,
    input int slow, output logic [9:0] r);
    @(posedge clk);
    #1;
    bus = {a, d, k, !w && !k[2], w};
    // RAM data passes two flops, so the answer is taken at the third edge
    repeat (3 + slow) @(posedge clk);
    r = {resp.wait_request, resp.data_in_enable, resp.data_in};
    #1;
    // Released lines float, so show changed values
    bus = {~a, ~d, 7'h0};
  endtask
endmodule // bjd_cpu

// File: verification/testbench.sv
// Bench: start jump, RAM, PROM and switch port traffic
`timescale 1ns/1ps
module testbench;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [5:0] rs = 6'h0, ps = 6'h0;
  logic [7:0] ss = 8'h0, sw = 8'h0, pa;
  logic [3:0] cs;
  logic jp;
  logic [9:0] r;
  logic [9:0] pofs;
  logic [9:0] ofs [8];
  logic [7:0] mem [8];
  int num_errors = 0, n_compared = 0;
  bjd_pkg::bjd_bus_s bus;
  bjd_pkg::bjd_resp_s resp;
  always #12.5 clk = ~clk;
  bjd_cpu i_bjd_cpu (.clk(clk), .bus(bus), .resp(resp));
  bjd_top i_bjd_top (.clk(clk), .reset_n(reset_n), .bus(bus), .resp(resp), .ram_window_sw(rs), .prom_window_sw(ps),
    .start_address_sw(ss), .switch_input_port(sw), .prom_chip_select(cs), .prom_addr(pa), .prom_data(~pa),
    .jump_in_progress(jp));
  task chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("compares %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function logic [15:0] target(input logic [7:0] s);
    return {s, 8'h00};
  endfunction
  task go(input logic [4:0] k, input logic [15:0] a, input logic [7:0] d = 8'h00, input logic w = 1'h0);
    i_bjd_cpu.acc(k, a, d, w, $urandom % 3, r);
  endtask
  initial
  begin
    logic [7:0] b [3];
    void'($urandom(31));
    // Second pass is a front-panel restart in mid-run
    repeat (2)
    begin
      reset_n = 1'h0;
      {rs, ps, ss, sw} = {1'h0, 5'($urandom), 1'h1, 5'($urandom), 16'($urandom)};
      repeat (16) @(posedge clk);
      #1;
      chk(jp, 1'h1);
      reset_n = 1'h1;
      @(posedge clk);
      #1;
      chk({resp.data_in_enable, resp.data_in}, 9'h1c3);
      for (int i = 0; i < 3; i++)
      begin
        chk(resp.memory_read_hold_n, 1'h0);
        go(5'h10, 16'(i));
        b[i] = r[7:0];
      end
      chk({b[0], b[1]}, 16'hc300);
      chk({b[2], b[1]}, target(ss));
      // Sequence ends on the edge that sees the last strobe low
      repeat (2) @(posedge clk);
      #1;
      chk({jp, resp.memory_read_hold_n}, 2'h1);
      for (int i = 0; i < 8; i++)
      begin
        ofs[i] = {3'(i), 7'($urandom)};
        mem[i] = 8'($urandom);
        go(5'h10, {rs, ofs[i]}, mem[i], 1'h1);
      end
      for (int i = 0; i < 8; i++)
      begin
        go(i[0] ? 5'h01 : 5'h10, {rs, ofs[i]});
        chk(r[8:0], {1'h1, mem[i]});
      end
      // Memory status together with interrupt must still keep RAM quiet
      go(5'h12, {rs, ofs[0]});
      chk(r[8], 1'h0);
      sw = 8'($urandom);
      go(5'h08, 16'hffff);
      chk(r, {2'h3, sw});
      go(5'h04, 16'hffff);
      chk(r[9:8], 2'h0);
      pofs = 10'($urandom);
      go(5'h10, {ps, pofs});
      chk(r, {2'h3, ~pofs[7:0]});
      chk({cs, pa}, {4'h1 << pofs[9:8], pofs[7:0]});
    end
    end_of_test;
  end
  // Whole run needs well under 1000 cycles
  initial
  begin
    #150000;
    num_errors++;
    end_of_test;
  end
endmodule // testbench
